/* logic/sfpc_pkg.sv */
// shared constants, types and register map of the serial flash pin controller
package sfpc_pkg;

   localparam int unsigned ADDR_W = 8;
   localparam int unsigned DATA_W = 32;
   localparam int unsigned PIN_W  = 6;

   // register byte offsets
   localparam logic [7:0] OFS_CTRL   = 8'h00;
   localparam logic [7:0] OFS_STATUS = 8'h04;
   localparam logic [7:0] OFS_RX     = 8'h08;
   localparam logic [7:0] OFS_TX     = 8'h0C;
   localparam logic [7:0] OFS_PINS   = 8'h10;

   // control register fields
   localparam int unsigned CTRL_MODE_LSB  = 0;
   localparam int unsigned CTRL_DRIVE_BIT = 2;
   localparam int unsigned CTRL_RPIN_BIT  = 3;
   localparam logic [3:0]  CTRL_RST       = 4'h0;

   // pin status register fields
   localparam int unsigned PINS_STATE_LSB = 0;
   localparam int unsigned PINS_RXV_BIT   = 2;
   localparam int unsigned PINS_TXP_BIT   = 3;
   localparam int unsigned PINS_REJ_BIT   = 4;
   localparam int unsigned PINS_OVR_BIT   = 5;
   localparam int unsigned PINS_WP_BIT    = 6;

   // status byte reset value, idle transmit byte, bits per byte
   localparam logic [7:0] SR_RST    = 8'h00;
   localparam logic [7:0] TX_IDLE   = 8'hFF;
   localparam logic [3:0] BYTE_BITS = 4'h8;

   typedef enum logic [1:0] {
      LANE_SINGLE,
      LANE_DUAL,
      LANE_QUAD
   } sfpc_lane_mode_type;

   typedef enum logic [1:0] {
      ST_IDLE,
      ST_SHIFT,
      ST_PAUSED,
      ST_HWRESET
   } sfpc_link_state_type;

   // status byte, most significant bit first
   typedef struct packed {
      logic       status_lock_bit;
      logic       quad_lane_enable_bit;
      logic [3:0] block_protect_bits;
      logic       write_enable_latch;
      logic       write_in_progress;
   } sfpc_status_type;

   // synchronised pin levels
   typedef struct packed {
      logic       sck;
      logic       select_n;
      logic [3:0] lane;
   } sfpc_pins_type;

endpackage

/* logic/sfpc_sync.sv */
// two-flop synchroniser for the pin inputs
module sfpc_sync
   import sfpc_pkg::*;
#(
   parameter int unsigned      WIDTH   = PIN_W,
   parameter logic [WIDTH-1:0] RST_VAL = '0
) (
   input  wire logic             clk,
   input  wire logic             resetn,
   input  wire logic [WIDTH-1:0] async_in,
   output logic      [WIDTH-1:0] sync_q
);

   logic [WIDTH-1:0] meta_q;

   // first stage feeds the second stage only; reset to the idle pin levels
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         meta_q <= RST_VAL;
         sync_q <= RST_VAL;
      end else begin
         meta_q <= async_in;
         sync_q <= meta_q;
      end
   end

endmodule

/* logic/sfpc_edge.sv */
// edge finder for the synchronised serial clock
module sfpc_edge
   import sfpc_pkg::*;
(
   input  wire logic clk,
   input  wire logic resetn,
   input  wire logic level,
   output logic      rise,
   output logic      fall
);

   logic prev_q;

   // previous level, one clock behind the synchronised one
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         prev_q <= 1'b0;
      end else begin
         prev_q <= level;
      end
   end

   // one-cycle pulses aligned with the synchronised lanes
   assign rise = level & ~prev_q;
   assign fall = ~level & prev_q;

endmodule

/* logic/sfpc_top.sv */
// serial flash pin controller: lane shifting, pause, reset pin and status protection
// Operation
// (R1) single mode: sample serial input on rising clock
// (R2) single mode: drive output lane on falling clock
// (R3) dual/quad: lanes 0,1 bidirectional, same edges
// (R4) quad mode uses lanes 2 and 3 too
// (R5) locked and protect pin low: reject protected writes
// (R6) lock clear: status writes always allowed
// (R7) quad enable set: ignore write-protect pin function
// (R8) lane 3 pause/reset only while quad disabled
// (R9) pause freezes transfer, keeps partial sequence
// (R10) pause while selected: output lanes float
// (R11) pause release resumes where it stopped
// (R12) reset pin low: reset, outputs float
// (R13) host avoids reset pin during internal writes
// (R14) deselected: outputs float, no data accepted
// (R15) clock idle low or high both work
// (R16) host releases lanes before device drives
module sfpc_top
   import sfpc_pkg::*;
(
   input  wire logic              clk,
   input  wire logic              resetn,
   input  wire logic              sck,
   input  wire logic              select_n,
   input  wire logic [3:0]        data_lane_in,
   output logic      [3:0]        data_lane_out_q,
   output logic      [3:0]        data_lane_oe_q,
   input  wire logic [ADDR_W-1:0] bus_addr,
   input  wire logic [DATA_W-1:0] bus_wdata,
   input  wire logic              bus_wr,
   input  wire logic              bus_rd,
   output logic      [DATA_W-1:0] bus_rdata_q
);

   sfpc_pins_type       pins_s;
   sfpc_status_type     status_q;
   sfpc_link_state_type state_q;
   sfpc_lane_mode_type  mode;
   logic [3:0]          ctrl_q;
   logic [7:0]          rx_shift_q;
   logic [7:0]          rx_byte_q;
   logic [3:0]          rx_cnt_q;
   logic [7:0]          tx_shift_q;
   logic [7:0]          tx_hold_q;
   logic [3:0]          tx_cnt_q;
   logic [7:0]          tx_cur;
   logic [7:0]          rx_next;
   logic [3:0]          step;
   logic                tx_pending_q;
   logic                rx_valid_q;
   logic                reject_q;
   logic                overrun_q;
   logic                seen_rise_q;
   logic                rise;
   logic                fall;
   logic                pause_now;
   logic                reset_now;
   logic                shift_ok;
   logic                rise_ok;
   logic                fall_ok;
   logic                byte_done;
   logic                protect;
   logic                sr_wr;
   logic                drive;

   // number of lanes moved per clock edge
   function automatic logic [3:0] lane_step(input sfpc_lane_mode_type m);
      case (m)
         LANE_DUAL: lane_step = 4'h2;
         LANE_QUAD: lane_step = 4'h4;
         default:   lane_step = 4'h1;
      endcase
   endfunction

   // lanes the device drives while returning data
   function automatic logic [3:0] lane_oe(input sfpc_lane_mode_type m);
      case (m)
         LANE_DUAL: lane_oe = 4'h3;
         LANE_QUAD: lane_oe = 4'hF;
         default:   lane_oe = 4'h2;
      endcase
   endfunction

   // top bits of the byte onto the lanes, lane 1 carries the msb in dual
   function automatic logic [3:0] lane_out(input logic [7:0] b, input sfpc_lane_mode_type m);
      case (m)
         LANE_DUAL: lane_out = {2'b00, b[7:6]};
         LANE_QUAD: lane_out = b[7:4];
         default:   lane_out = {2'b00, b[7], 1'b0};
      endcase
   endfunction

   // pins cross into the clk domain before anything looks at them
   // idle levels after reset: a zero select or lane 3 would look like a select and a pause
   sfpc_sync #(.WIDTH(PIN_W), .RST_VAL(6'h1F)) u_sync (
      .clk      (clk),
      .resetn   (resetn),
      .async_in ({sck, select_n, data_lane_in}),
      .sync_q   (pins_s)
   );

   sfpc_edge u_edge (
      .clk    (clk),
      .resetn (resetn),
      .level  (pins_s.sck),
      .rise   (rise),
      .fall   (fall)
   );

   // quad is only honoured with quad enable set; otherwise single lane
   always_comb begin
      case (ctrl_q[CTRL_MODE_LSB +: 2])
         2'h1:    mode = LANE_DUAL;
         2'h2:    mode = status_q.quad_lane_enable_bit ? LANE_QUAD : LANE_SINGLE; // R4
         default: mode = LANE_SINGLE;
      endcase
   end

   // lane 3 is pause or reset only while quad enable is clear
   assign pause_now = ~status_q.quad_lane_enable_bit & ~ctrl_q[CTRL_RPIN_BIT]
                    & ~pins_s.lane[3] & ~pins_s.select_n;                        // R8
   assign reset_now = ~status_q.quad_lane_enable_bit & ctrl_q[CTRL_RPIN_BIT]
                    & ~pins_s.lane[3];                                            // R12
   assign step     = lane_step(mode);
   assign drive    = ctrl_q[CTRL_DRIVE_BIT];
   assign shift_ok = (state_q == ST_SHIFT) & ~pause_now & ~pins_s.select_n & ~reset_now;
   assign rise_ok  = rise & shift_ok;                                             // R1 R14
   // falling edges before the first rise are skipped so an idle-high clock works
   assign fall_ok  = fall & shift_ok & seen_rise_q & drive;                      // R15
   assign tx_cur   = (tx_cnt_q != 4'h0) ? tx_shift_q : (tx_pending_q ? tx_hold_q : TX_IDLE);
   assign byte_done = rise_ok & ((rx_cnt_q + step) == BYTE_BITS);

   // shift the sampled lanes in, lane 0 is the least significant
   always_comb begin
      case (mode)
         LANE_DUAL: rx_next = {rx_shift_q[5:0], pins_s.lane[1:0]};               // R3
         LANE_QUAD: rx_next = {rx_shift_q[3:0], pins_s.lane};                    // R4
         default:   rx_next = {rx_shift_q[6:0], pins_s.lane[0]};                 // R1
      endcase
   end

   // with quad enable set the protect pin is a data lane only
   assign protect = status_q.status_lock_bit & ~pins_s.lane[2]
                  & ~status_q.quad_lane_enable_bit;                               // R5 R7
   assign sr_wr   = bus_wr & (bus_addr == OFS_STATUS);

   // link state follows select, pause and reset pin
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         state_q <= ST_IDLE;
      end else if (reset_now) begin
         state_q <= ST_HWRESET;                                                   // R12
      end else begin
         case (state_q)
            ST_IDLE:    if (!pins_s.select_n) state_q <= ST_SHIFT;
            ST_SHIFT: begin
               if (pins_s.select_n) state_q <= ST_IDLE;                           // R14
               else if (pause_now) state_q <= ST_PAUSED;                          // R9
            end
            ST_PAUSED: begin
               if (pins_s.select_n) state_q <= ST_IDLE;
               else if (!pause_now) state_q <= ST_SHIFT;                          // R11
            end
            ST_HWRESET: state_q <= ST_IDLE;
            default:    state_q <= ST_IDLE;
         endcase
      end
   end

   // receive path; a pause simply stops edges so the count is kept
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         rx_shift_q  <= 8'h00;
         rx_cnt_q    <= 4'h0;
         rx_byte_q   <= 8'h00;
         seen_rise_q <= 1'b0;
      end else if (pins_s.select_n || reset_now) begin
         rx_cnt_q    <= 4'h0;                                                     // R14
         seen_rise_q <= 1'b0;
      end else if (rise_ok) begin
         rx_shift_q  <= rx_next;                                                  // R1 R3
         rx_cnt_q    <= byte_done ? 4'h0 : rx_cnt_q + step;
         seen_rise_q <= 1'b1;
         if (byte_done) rx_byte_q <= rx_next;
      end
   end

   // transmit path, new bits only on falling clock edges
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         tx_shift_q      <= 8'h00;
         tx_cnt_q        <= 4'h0;
         data_lane_out_q <= 4'h0;
      end else if (pins_s.select_n || reset_now) begin
         tx_cnt_q <= 4'h0;
      end else if (fall_ok) begin
         data_lane_out_q <= lane_out(tx_cur, mode);                               // R2 R3
         tx_shift_q      <= tx_cur << step;
         tx_cnt_q        <= ((tx_cnt_q + step) == BYTE_BITS) ? 4'h0 : tx_cnt_q + step;
      end
   end

   // enables drop one clock after deselect, pause or reset pin
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         data_lane_oe_q <= 4'h0;
      end else if (shift_ok && drive) begin
         data_lane_oe_q <= lane_oe(mode);                                         // R3 R4
      end else begin
         data_lane_oe_q <= 4'h0;                                                  // R10 R12 R14
      end
   end

   // control register
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         ctrl_q <= CTRL_RST;
      end else if (bus_wr && bus_addr == OFS_CTRL) begin
         ctrl_q <= bus_wdata[3:0];
      end
   end

   // status byte; the reset pin drops the write latch after any write
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         status_q <= SR_RST;
      end else begin
         if (sr_wr && protect) begin
            status_q[1:0] <= bus_wdata[1:0];                                      // R5
         end else if (sr_wr) begin
            status_q <= bus_wdata[7:0];                                           // R6 R7
         end
         if (reset_now) status_q.write_enable_latch <= 1'b0;
      end
   end

   // transmit holding byte; a write racing the load keeps pending set
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         tx_hold_q    <= TX_IDLE;
         tx_pending_q <= 1'b0;
      end else if (bus_wr && bus_addr == OFS_TX) begin
         tx_hold_q    <= bus_wdata[7:0];
         tx_pending_q <= 1'b1;
      end else if (fall_ok && tx_cnt_q == 4'h0) begin
         tx_pending_q <= 1'b0;
      end
   end

   // sticky flags, the set wins over a clearing read in the same cycle
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         rx_valid_q <= 1'b0;
         overrun_q  <= 1'b0;
         reject_q   <= 1'b0;
      end else begin
         if (byte_done) rx_valid_q <= 1'b1;
         else if (bus_rd && bus_addr == OFS_RX) rx_valid_q <= 1'b0;
         if (byte_done && rx_valid_q) overrun_q <= 1'b1;
         else if (bus_rd && bus_addr == OFS_PINS) overrun_q <= 1'b0;
         if (sr_wr && protect) reject_q <= 1'b1;
         else if (bus_rd && bus_addr == OFS_PINS) reject_q <= 1'b0;
      end
   end

   // read data valid in the cycle after the strobe only; unmapped reads zero
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         bus_rdata_q <= '0;
      end else if (bus_rd) begin
         case (bus_addr)
            OFS_CTRL:   bus_rdata_q <= {28'h0000000, ctrl_q};
            OFS_STATUS: bus_rdata_q <= {24'h000000, status_q};
            OFS_RX:     bus_rdata_q <= {24'h000000, rx_byte_q};
            OFS_TX:     bus_rdata_q <= {24'h000000, tx_hold_q};
            OFS_PINS:   bus_rdata_q <= {25'h0000000, pins_s.lane[2], overrun_q, reject_q,
                                        tx_pending_q, rx_valid_q, state_q};
            default:    bus_rdata_q <= '0;
         endcase
      end else begin
         bus_rdata_q <= '0;
      end
   end

   default clocking cb @(posedge clk); endclocking
   default disable iff (!resetn);

   a_deselect_float: assert property (pins_s.select_n |=> data_lane_oe_q == 4'h0) // R14
      else $error("lanes driven while deselected");
   a_pause_float: assert property (pause_now |=> data_lane_oe_q == 4'h0) // R10
      else $error("lanes driven during pause");
   a_reset_float: assert property (reset_now |=> data_lane_oe_q == 4'h0 ##1
                                   state_q != ST_SHIFT) // R12
      else $error("reset pin did not float outputs");
   a_pause_keeps: assert property (pause_now && !reset_now |=>
                                   $stable(rx_cnt_q) && $stable(rx_shift_q)) // R9
      else $error("pause disturbed the partial sequence");
   a_resume_shift: assert property (state_q == ST_PAUSED && !pause_now && !reset_now
                                    && !pins_s.select_n |=> state_q == ST_SHIFT) // R11
      else $error("no resume after pause release");
   a_locked_reject: assert property (sr_wr && protect |=>
                                     status_q[7:2] == $past(status_q[7:2]) && reject_q) // R5
      else $error("protected status bits changed");
   a_unlocked_write: assert property (sr_wr && !status_q.status_lock_bit && !reset_now |=>
                                      status_q == $past(bus_wdata[7:0])) // R6
      else $error("unlocked status write lost");
   a_quad_ignores_wp: assert property (sr_wr && status_q.quad_lane_enable_bit |=>
                                       status_q[7:2] == $past(bus_wdata[7:2])) // R7
      else $error("protect pin acted in quad mode");
   a_quad_no_pause: assert property (status_q.quad_lane_enable_bit |=>
                                     state_q != ST_PAUSED && state_q != ST_HWRESET) // R8
      else $error("lane 3 acted as pause or reset");
   a_single_sample: assert property (rise_ok && mode == LANE_SINGLE |=>
                                     rx_shift_q[0] == $past(pins_s.lane[0])) // R1
      else $error("serial input not sampled on rise");
   a_fall_update: assert property ($changed(data_lane_out_q) |-> $past(fall_ok)) // R2
      else $error("output lane moved off a falling edge");
   a_quad_lanes: assert property (shift_ok && drive && mode == LANE_QUAD |=>
                                  data_lane_oe_q == 4'hF) // R4
      else $error("quad read not on four lanes");
   a_idle_high_start: assert property (fall && !seen_rise_q |=> $stable(tx_cnt_q)) // R15
      else $error("fall before first rise shifted data");

   c_byte_in: cover property (byte_done);
   c_quad_drive: cover property (fall_ok && mode == LANE_QUAD);
   c_pause_resume: cover property (state_q == ST_PAUSED ##1 state_q == ST_SHIFT);
   c_reject: cover property (sr_wr && protect);

endmodule

/* dv/sfpc_host.sv */
// behavioural serial bus master that drives the flash pins
module sfpc_host (
   output logic            sck,
   output logic            select_n,
   output logic      [3:0] lane_level,
   input  wire logic [3:0] dev_out,
   input  wire logic [3:0] dev_oe
);
   timeunit 1ns;
   timeprecision 100ps;

   logic [3:0] host_oe;
   logic [3:0] host_val;
   logic       ctl_pins;
   logic       wp_lvl;
   logic       l3_lvl;
   logic       idle_lvl;
   logic [3:0] paused_oe;
   int         pause_at;

   // device wins where it drives; released lanes rest on their pull-ups
   always_comb begin
      for (int b = 0; b < 4; b++) begin
         if (dev_oe[b]) begin
            lane_level[b] = dev_out[b];
         end else if (ctl_pins && b >= 2) begin
            lane_level[b] = (b == 3) ? l3_lvl : wp_lvl;
         end else begin
            lane_level[b] = host_oe[b] ? host_val[b] : 1'b1;
         end
      end
   end

   // idle pins at time zero
   initial begin
      sck = 1'b0;
      select_n = 1'b1;
      host_oe = 4'h0;
      host_val = 4'h0;
      ctl_pins = 1'b1;
      wp_lvl = 1'b1;
      l3_lvl = 1'b1;
      idle_lvl = 1'b0;
      pause_at = -1;
   end

   // lanes are set up before select so nobody fights the device later
   task automatic sel(input bit on, input int n, input bit rd, input bit m3);
      #7;
      if (on) begin
         ctl_pins = (n != 4);
         host_oe = (n == 1) ? 4'h1 : (rd ? 4'h0 : ((n == 2) ? 4'h3 : 4'hF));
         idle_lvl = m3;
         sck = m3;
         #80 select_n = 1'b0;
      end else begin
         #80 select_n = 1'b1;
         host_oe = 4'h0;
         ctl_pins = 1'b1;
      end
      #200;
   endtask

   function automatic logic [7:0] grab(input logic [7:0] acc, input int n);
      logic [3:0] v;
      v = (n == 1) ? {3'h0, lane_level[1]} : lane_level & ((4'h1 << n) - 4'h1);
      return (acc << n) | {4'h0, v};
   endfunction

   // one byte, msb first; read bits are taken late in the high phase, the last one 160 ns after the closing fall
   task automatic xfer(input logic [7:0] tx, input int n, output logic [7:0] rx);
      logic [7:0] sh;
      sh = tx;
      rx = 8'h00;
      for (int i = 0; i < 8 / n; i++) begin
         if (i == pause_at) begin
            l3_lvl = 1'b0;
            #400 paused_oe = dev_oe;
            l3_lvl = 1'b1;
            #400;
         end
         sck = 1'b0;
         host_val = sh[7 -: 4] >> (4 - n);
         sh = sh << n;
         #80 sck = 1'b1;
         #80;
         if (i > 0) rx = grab(rx, n);
      end
      // an idle-high write ends on its last rise; one more fall and rise would shift again
      if (!idle_lvl || dev_oe != 4'h0) begin
         sck = 1'b0;
         #160 rx = grab(rx, n);
      end
      sck = idle_lvl;
   endtask
endmodule

/* dv/sfpc_top_bench.sv */
// self-checking bench for the serial flash pin controller
module sfpc_top_bench
   import sfpc_pkg::*;
;
   timeunit 1ns;
   timeprecision 100ps;

   logic              clk;
   logic              resetn;
   wire               sck;
   wire               select_n;
   wire  [3:0]        lane_level;
   logic [3:0]        out_q;
   logic [3:0]        oe_q;
   logic [ADDR_W-1:0] bus_addr;
   logic [DATA_W-1:0] bus_wdata;
   logic              bus_wr;
   logic              bus_rd;
   logic [DATA_W-1:0] bus_rdata_q;
   int                errors;
   int                samples_checked;
   logic [7:0]        got;
   logic [7:0]        txv [3] = '{8'hA5, 8'h96, 8'h5A};
   logic [3:0]        oev [3] = '{4'h2, 4'h3, 4'hF};

   sfpc_top u_dut (
      .clk(clk), .resetn(resetn), .sck(sck), .select_n(select_n),
      .data_lane_in(lane_level), .data_lane_out_q(out_q), .data_lane_oe_q(oe_q),
      .bus_addr(bus_addr), .bus_wdata(bus_wdata), .bus_wr(bus_wr), .bus_rd(bus_rd),
      .bus_rdata_q(bus_rdata_q)
   );

   sfpc_host u_host (
      .sck(sck), .select_n(select_n), .lane_level(lane_level),
      .dev_out(out_q), .dev_oe(oe_q)
   );

   always #10 clk = ~clk;

   task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         errors++;
         $display("BAD %s expected %h seen %h", what, exp, seen);
      end
   endtask

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge clk);
      bus_addr <= a;
      bus_wdata <= d;
      bus_wr <= 1'b1;
      @(posedge clk);
      bus_wr <= 1'b0;
   endtask

   // an empty name reads only for the side effect of clearing flags
   task automatic rd(input logic [7:0] a, input logic [31:0] exp, input string what);
      @(posedge clk);
      bus_addr <= a;
      bus_rd <= 1'b1;
      @(posedge clk);
      bus_rd <= 1'b0;
      #1;
      if (what != "") check(what, bus_rdata_q, exp);
   endtask

   task automatic settle();
      repeat (10) @(posedge clk);
      #1;
   endtask

   task automatic conclude();
      $display("comparisons %0d mismatches %0d", samples_checked, errors);
      if (errors == 0 && samples_checked > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask

   // a hang is cut off well past the few tens of microseconds the tests need
   initial begin
      #500000;
      errors++;
      conclude();
   end

   initial begin
      clk = 1'b0;
      resetn = 1'b0;
      bus_addr = 8'h00;
      bus_wdata = 32'h0;
      bus_wr = 1'b0;
      bus_rd = 1'b0;
      errors = 0;
      samples_checked = 0;
      repeat (8) @(posedge clk);
      resetn <= 1'b1;
      settle();
      check("idle oe", oe_q, 4'h0);
      rd(OFS_CTRL, 32'h0, "ctrl");
      rd(OFS_STATUS, {24'h0, SR_RST}, "status");
      rd(OFS_TX, {24'h0, TX_IDLE}, "tx");
      rd(8'h14, 32'h0, "unmapped");
      rd(OFS_PINS, 32'h40, "pins");
      $display("test defaults done");

      // status protection by lock bit, protect pin and quad enable
      u_host.wp_lvl = 1'b0;
      settle();
      wr(OFS_STATUS, 32'hBC);
      rd(OFS_STATUS, 32'hBC, "unlocked write");
      wr(OFS_STATUS, 32'h00);
      rd(OFS_STATUS, 32'hBC, "locked write");
      rd(OFS_PINS, 32'h10, "reject flag");
      rd(OFS_PINS, 32'h00, "reject cleared");
      u_host.wp_lvl = 1'b1;
      settle();
      wr(OFS_STATUS, 32'h80);
      rd(OFS_STATUS, 32'h80, "pin high write");
      wr(OFS_STATUS, 32'hC0);
      u_host.wp_lvl = 1'b0;
      settle();
      wr(OFS_STATUS, 32'h00);
      rd(OFS_STATUS, 32'h00, "quad ignores pin");
      u_host.wp_lvl = 1'b1;
      $display("test protection done");

      // receive in both clock polarities
      wr(OFS_CTRL, 32'h0);
      for (int m = 0; m < 2; m++) begin
         u_host.sel(1, 1, 0, m[0]);
         u_host.xfer(m ? 8'hC3 : 8'h3C, 1, got);
         u_host.sel(0, 1, 0, m[0]);
         rd(OFS_RX, m ? 32'hC3 : 32'h3C, "rx byte");
      end
      // two bytes in one frame with no read between them flag an overrun
      u_host.sel(1, 1, 0, 1'b0);
      u_host.xfer(8'h12, 1, got);
      u_host.xfer(8'h34, 1, got);
      u_host.sel(0, 1, 0, 1'b0);
      rd(OFS_PINS, 32'h64, "overrun");
      rd(OFS_RX, 32'h34, "second byte");
      $display("test receive done");

      // single, dual and quad reads; pause is ignored while quad enable is set
      wr(OFS_STATUS, 32'h40);
      for (int k = 0; k < 3; k++) begin
         wr(OFS_TX, {24'h0, txv[k]});
         wr(OFS_CTRL, 32'h4 + k);
         u_host.pause_at = (k == 0) ? 2 : -1;
         u_host.sel(1, 1 << k, 1, 1'b0);
         check("lane oe", oe_q, oev[k]);
         u_host.xfer(8'h00, 1 << k, got);
         check("read byte", got, txv[k]);
         u_host.sel(0, 1 << k, 1, 1'b0);
         check("oe deselected", oe_q, 4'h0);
         rd(OFS_RX, 32'h0, "");
      end
      check("pause ignored", u_host.paused_oe, 4'h2);
      rd(OFS_PINS, 32'h0, "");
      $display("test lane reads done");

      // pause in mid byte keeps the partial sequence in both directions
      wr(OFS_STATUS, 32'h00);
      wr(OFS_TX, 32'hA5);
      // quad asked for with quad enable clear runs as single lane
      wr(OFS_CTRL, 32'h6);
      u_host.pause_at = 3;
      u_host.sel(1, 1, 1, 1'b0);
      u_host.xfer(8'h69, 1, got);
      u_host.sel(0, 1, 1, 1'b0);
      u_host.pause_at = -1;
      check("paused oe", u_host.paused_oe, 4'h0);
      check("resumed read", got, 8'hA5);
      rd(OFS_RX, 32'h69, "resumed rx");
      $display("test pause done");

      // reset pin asserted with no internal write running
      wr(OFS_STATUS, 32'h02);
      rd(OFS_STATUS, 32'h02, "latch set");
      wr(OFS_CTRL, 32'hC);
      u_host.sel(1, 1, 1, 1'b0);
      check("drive before reset", oe_q, 4'h2);
      u_host.l3_lvl = 1'b0;
      settle();
      check("reset oe", oe_q, 4'h0);
      rd(OFS_PINS, 32'h43, "reset state");
      u_host.l3_lvl = 1'b1;
      u_host.sel(0, 1, 1, 1'b0);
      rd(OFS_STATUS, 32'h00, "latch cleared");
      $display("test reset pin done");

      // clocking while deselected must not be taken in
      wr(OFS_CTRL, 32'h0);
      u_host.xfer(8'h5A, 1, got);
      settle();
      rd(OFS_PINS, 32'h40, "deselected pins");
      check("deselected oe", oe_q, 4'h0);
      $display("test deselect done");
      conclude();
   end
endmodule
